// >>> design/quad_dac_ctrl.sv
`timescale 1ns/100ps
`include "quad_dac_consts.svh"
// Overview of operation
// - Frame select low starts a write; data ignored while it is high.
// - While framed, data sampled on each serial clock fall into 16-bit shift.
// - Sixteenth fall captures last bit and executes the command.
// - Clock falls after the sixteenth are ignored until frame ends.
// - Frame released before sixteenth fall aborts; nothing changes but the abort count.
// - First two bits are the channel address.
// - Next two bits are the operation mode.
// - Last twelve bits are straight binary data, MSB first.
// - Each channel register holds a code from 0 to 1023.
// - Reset clears registers and outputs to zero until a valid write.
// - Mode 11 powers down all channels whatever the address.
// - Power-down address selects termination: high-Z, 2.5k or 100k.
// - Power-down keeps registers; the waking write may change them.
// - One code step is reference divided by 1024.
module quad_dac_ctrl
    import quad_dac_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic frame_n_pin,
    input wire logic sclk_pin,
    input wire logic sdata_pin,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output quad_dac_pkg::code_t out_code_a,
    output quad_dac_pkg::code_t out_code_b,
    output quad_dac_pkg::code_t out_code_c,
    output quad_dac_pkg::code_t out_code_d,
    output logic powered_down,
    output quad_dac_pkg::term_e out_term
);
    import quad_dac_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE
    } link_state_e;

    logic frame_n;
    logic sdata;
    logic sclk_fall;
    link_state_e state_reg;
    link_state_e state_next;
    logic [`WORD_BITS-1:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    code_t code_reg [NUM_CH];
    code_t out_reg [NUM_CH];
    logic pd_reg;
    term_e term_reg;
    logic [7:0] abort_cnt_reg;
    logic [15:0] word_cnt_reg;
    logic ctrl_en_reg;
    logic [31:0] rd_value;
    logic [7:0] rd_addr;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;

    link_sampler u_link (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .frame_n_pin(frame_n_pin),
        .sclk_pin(sclk_pin),
        .sdata_pin(sdata_pin),
        .frame_n(frame_n),
        .sdata(sdata),
        .sclk_fall(sclk_fall)
    );

    ahb_regs u_regs (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rd_value(rd_value),
        .rd_addr(rd_addr),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // Channel index from the two address bits
    function automatic logic [1:0] chan_of(input logic [`WORD_BITS-1:0] w);
        chan_of = {w[`ADDR_HI_POS], w[`ADDR_LO_POS]};
    endfunction

    // Word complete: the 16th fall in this cycle, with the bit appended
    wire logic [`WORD_BITS-1:0] word_full = {shift_reg[`WORD_BITS-2:0], sdata};
    wire logic word_done = (state_reg == ST_SHIFT) & sclk_fall & ~frame_n
        & (bit_cnt_reg == 5'(`WORD_BITS - 1));
    wire logic exec = word_done & ctrl_en_reg;
    wire op_mode_e op = op_mode_e'({word_full[`OP_HI_POS], word_full[`OP_LO_POS]});
    wire logic [1:0] sel = chan_of(word_full);
    // top ten of twelve MSB-first data bits form the code
    wire code_t new_code = word_full[`DATA_MSB_POS:`CODE_LSB_POS];
    wire logic do_update = exec & (op == OP_WRITE_UPDATE || op == OP_WRITE_ALL);

    // Link sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (!frame_n) begin
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (frame_n) begin
                    state_next = ST_IDLE;
                end else if (word_done) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (frame_n) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Shift register and bit count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            shift_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
        end else if (ce) begin
            state_reg <= state_next;
            if (state_reg != ST_SHIFT) begin
                bit_cnt_reg <= 5'h00;
            end else if (sclk_fall && !frame_n) begin
                shift_reg <= word_full;
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // Channel input and output registers, one set per channel
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        wire logic wr_me = exec & (op == OP_WRITE_ALL
            || ((op == OP_WRITE_HOLD || op == OP_WRITE_UPDATE) && sel == 2'(i)));
        // ten-bit code, 0 to 1023; step is ref/1024
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                code_reg[i] <= `CODE_RESET;
                out_reg[i] <= `CODE_RESET;
            end else if (ce) begin
                if (wr_me) begin
                    code_reg[i] <= new_code;
                end
                if (do_update) begin
                    out_reg[i] <= (op == OP_WRITE_ALL || sel == 2'(i)) ? new_code
                        : code_reg[i];
                end
            end
        end
    end

    // Power-down state and counters
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pd_reg <= 1'b0;
            term_reg <= TERM_HIGH_Z;
            abort_cnt_reg <= 8'h00;
            word_cnt_reg <= 16'h0000;
        end else if (ce) begin
            if (exec) begin
                // mode 11 powers all down; codes untouched
                pd_reg <= (op == OP_POWER_DOWN);
                if (op == OP_POWER_DOWN) begin
                    term_reg <= term_e'(sel);
                end
            end
            if (word_done) begin
                word_cnt_reg <= word_cnt_reg + 16'h0001;
            end
            if (state_reg == ST_SHIFT && frame_n) begin
                abort_cnt_reg <= abort_cnt_reg + 8'h01;
            end
        end
    end

    // Software control: bit 0 lets link words execute
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_en_reg <= 1'b1;
        end else if (ce && wr_stb && wr_addr == `OFS_CTRL) begin
            ctrl_en_reg <= wr_data[0];
        end
    end

    // Read mux; unmapped offsets read zero
    assign rd_value =
        (rd_addr == `OFS_CODE_A) ? {22'h0, code_reg[0]} :
        (rd_addr == `OFS_CODE_B) ? {22'h0, code_reg[1]} :
        (rd_addr == `OFS_CODE_C) ? {22'h0, code_reg[2]} :
        (rd_addr == `OFS_CODE_D) ? {22'h0, code_reg[3]} :
        (rd_addr == `OFS_OUT_A) ? {22'h0, out_reg[0]} :
        (rd_addr == `OFS_OUT_B) ? {22'h0, out_reg[1]} :
        (rd_addr == `OFS_OUT_C) ? {22'h0, out_reg[2]} :
        (rd_addr == `OFS_OUT_D) ? {22'h0, out_reg[3]} :
        (rd_addr == `OFS_STATUS) ? {word_cnt_reg, abort_cnt_reg, 5'h0, term_reg, pd_reg} :
        (rd_addr == `OFS_CTRL) ? {31'h0, ctrl_en_reg} : 32'h0000_0000;

    assign out_code_a = out_reg[0];
    assign out_code_b = out_reg[1];
    assign out_code_c = out_reg[2];
    assign out_code_d = out_reg[3];
    assign powered_down = pd_reg;
    assign out_term = term_reg;

    AST_ABORT_KEEPS: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_reg == ST_SHIFT && frame_n) |=> $stable(out_reg[0]) && $stable(pd_reg))
        else $error("abort changed state");
    // write-all mode moves output next cycle
    AST_UPDATE: assert property (@(posedge clk_sys) disable iff (rst)
        (exec && op == OP_WRITE_ALL) |=> out_reg[0] == $past(new_code))
        else $error("write-all did not update output");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (exec && op == OP_WRITE_HOLD) |=> $stable(out_reg[1]))
        else $error("hold mode moved output");
    AST_PD: assert property (@(posedge clk_sys) disable iff (rst)
        (exec && op == OP_POWER_DOWN) |=> pd_reg && $stable(code_reg[2]))
        else $error("power-down wrong");
    AST_TERM: assert property (@(posedge clk_sys) disable iff (rst)
        (exec && op == OP_POWER_DOWN) |=> term_reg == term_e'($past(sel)))
        else $error("termination wrong");
    // after completion state waits for frame end
    AST_DONE_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_reg == ST_DONE && !frame_n) |=> state_reg == ST_DONE)
        else $error("left done early");
    AST_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_reg == ST_SHIFT && !frame_n && !sclk_fall) |=> $stable(bit_cnt_reg))
        else $error("count moved without fall");
    // idle with frame high stays idle
    AST_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_reg == ST_IDLE && frame_n) |=> state_reg == ST_IDLE && $stable(shift_reg))
        else $error("idle moved");
    AST_RESET: assert property (@(posedge clk_sys)
        rst |=> out_reg[3] == `CODE_RESET && !pd_reg)
        else $error("reset value wrong");
endmodule

// >>> common/quad_dac_consts.svh
`ifndef QUAD_DAC_CONSTS_SVH
`define QUAD_DAC_CONSTS_SVH
// Serial word layout, first bit shifted in lands at bit 15
`define WORD_BITS 16
`define ADDR_HI_POS 15
`define ADDR_LO_POS 14
`define OP_HI_POS 13
`define OP_LO_POS 12
`define DATA_MSB_POS 11
`define CODE_LSB_POS 2
`define CODE_BITS 10
// Reset values
`define CODE_RESET 10'h000
// Register map (byte addresses)
`define OFS_CODE_A 8'h00
`define OFS_CODE_B 8'h04
`define OFS_CODE_C 8'h08
`define OFS_CODE_D 8'h0c
`define OFS_OUT_A 8'h10
`define OFS_OUT_B 8'h14
`define OFS_OUT_C 8'h18
`define OFS_OUT_D 8'h1c
`define OFS_STATUS 8'h20
`define OFS_CTRL 8'h24
`define CTRL_RESET 32'h0000_0001
// Status fields
`define ST_PD_POS 0
`define ST_TERM_LSB 1
`define ST_ABORT_CNT_LSB 8
`define ST_WORD_CNT_LSB 16
`endif

// >>> common/quad_dac_pkg.sv
package quad_dac_pkg;
    typedef enum logic [1:0] {
        OP_WRITE_HOLD,
        OP_WRITE_UPDATE,
        OP_WRITE_ALL,
        OP_POWER_DOWN
    } op_mode_e;
    typedef enum logic [1:0] {
        TERM_HIGH_Z,
        TERM_2K5_GND,
        TERM_100K_GND,
        TERM_HIGH_Z_ALT
    } term_e;
    typedef logic [9:0] code_t;
endpackage

// >>> design/link_sampler.sv
`timescale 1ns/100ps
`include "quad_dac_consts.svh"
// Brings frame select, serial clock and data into clk_sys, finds clock falls
module link_sampler (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic frame_n_pin,
    input wire logic sclk_pin,
    input wire logic sdata_pin,
    output logic frame_n,
    output logic sdata,
    output logic sclk_fall
);
    logic [1:0] frame_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] data_sync_reg;
    logic sclk_prev_reg;

    // Two stages per pin; only the second stage feeds logic
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_sync_reg <= 2'h3;
            sclk_sync_reg <= 2'h0;
            data_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
        end else if (ce) begin
            frame_sync_reg <= {frame_sync_reg[0], frame_n_pin};
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_pin};
            data_sync_reg <= {data_sync_reg[0], sdata_pin};
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end

    // Fall seen in the cycle the synced level drops; data is aligned with it
    assign frame_n = frame_sync_reg[1];
    assign sdata = data_sync_reg[1];
    assign sclk_fall = ce & sclk_prev_reg & ~sclk_sync_reg[1];
endmodule

// >>> design/ahb_regs.sv
`timescale 1ns/100ps
`include "quad_dac_consts.svh"
// AHB-Lite slave, zero wait states, always OKAY
module ahb_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [31:0] rd_value,
    output logic [7:0] rd_addr,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data
);
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] rdata_reg;
    wire logic take = ce & hsel & hready & htrans[1];

    // Address phase capture
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend_reg <= take & hwrite;
            if (take) begin
                addr_reg <= haddr[7:0];
            end
            if (take & ~hwrite) begin
                rdata_reg <= rd_value;
            end
        end
    end

    // Read value picked at address phase, held for the data phase
    assign rd_addr = haddr[7:0];
    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_stb = ce & wr_pend_reg;
    assign wr_addr = addr_reg;
    assign wr_data = hwdata;
endmodule

// >>> dv/serial_host.sv
`timescale 1ns/100ps
// Host end of the three-wire link: clock idles low, data changes on the rise
module serial_host (
    output logic frame_n_pin,
    output logic sclk_pin,
    output logic sdata_pin
);
    // Frame starts high so reset sees no frame
    initial begin
        frame_n_pin = 1'b1;
        sclk_pin = 1'b0;
        sdata_pin = 1'b0;
    end

    // Bits past sixteen are junk; a short count ends in a raised frame
    task automatic send(input logic [15:0] w, input int n, input bit split);
        frame_n_pin <= 1'b1;
        #100;
        frame_n_pin <= 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            // polarity 0 phase 1, 125 ns
            sclk_pin <= 1'b1;
            sdata_pin <= (i < 16) ? w[15 - i] : ~w[i - 16];
            #62.5;
            sclk_pin <= 1'b0;
            #62.5;
            if (split && i == 7) #300;
        end
        #40;
        sdata_pin <= 1'b0;
        if (n < 16) frame_n_pin <= 1'b1;
    endtask
endmodule

// >>> dv/tb_quad_dac_serial_write_control.sv
`timescale 1ns/100ps
`include "quad_dac_consts.svh"
module tb_quad_dac_serial_write_control;
    import quad_dac_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    code_t outs [4];
    logic powered_down;
    term_e out_term;
    logic frame_n_pin;
    logic sclk_pin;
    logic sdata_pin;
    int miscompares = 0;
    int cmp_count = 0;
    code_t exp_code [4] = '{default: 10'h000};
    code_t exp_out [4] = '{default: 10'h000};
    logic exp_pd = 1'b0;
    term_e exp_term = TERM_HIGH_Z;
    logic [15:0] exp_words = 16'h0;
    logic [7:0] exp_aborts = 8'h0;
    logic exec = 1'b1;
    logic ce = 1'b1;
    logic [31:0] seed = 32'h0000002e;

    // The one slave's ready is the bus ready
    assign hready = hreadyout;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    quad_dac_ctrl dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .frame_n_pin(frame_n_pin),
        .sclk_pin(sclk_pin), .sdata_pin(sdata_pin), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_code_a(outs[0]),
        .out_code_b(outs[1]), .out_code_c(outs[2]), .out_code_d(outs[3]),
        .powered_down(powered_down), .out_term(out_term));

    serial_host host (.frame_n_pin(frame_n_pin), .sclk_pin(sclk_pin), .sdata_pin(sdata_pin));

    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard well above the expected run time
    initial begin
        #600000;
        miscompares++;
        end_of_test();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait for ready at a rising edge
    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge clk_sys);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                miscompares++;
                end_of_test();
            end
            @(posedge clk_sys);
        end
    endtask

    // Single word transfer: address phase held to ready, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk_sys);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected effect of one executed word
    function automatic void apply(input logic [15:0] w);
        logic [1:0] a;
        code_t c;
        a = w[15:14];
        c = w[11:2];
        exp_pd = (w[13:12] == 2'h3);
        if (exp_pd) begin
            exp_term = term_e'(a);
        end else if (w[13:12] == 2'h2) begin
            exp_code = '{default: c};
            exp_out = '{default: c};
        end else begin
            exp_code[a] = c;
            if (w[13:12] == 2'h1) exp_out = exp_code;
        end
    endfunction

    task automatic check_all();
        logic [31:0] r;
        repeat (10) @(posedge clk_sys);
        #1;
        for (int i = 0; i < 4; i++) begin
            chk({22'h0, outs[i]}, {22'h0, exp_out[i]});
            ahb(1'b0, 8'(4 * i), 32'h0, r);
            chk(r, {22'h0, exp_code[i]});
        end
        chk({31'h0, powered_down}, {31'h0, exp_pd});
        if (exp_pd) chk({30'h0, out_term}, {30'h0, exp_term});
        ahb(1'b0, `OFS_STATUS, 32'h0, r);
        chk({7'h0, r[31:8], r[0]}, {7'h0, exp_words, exp_aborts, exp_pd});
    endtask

    // Send a frame and keep the expected state in step
    task automatic word(input logic [15:0] w, input int n, input bit split);
        host.send(w, n, split);
        if (n >= 16) begin
            exp_words++;
            if (exec) apply(w);
        end else begin
            exp_aborts++;
        end
        check_all();
    endtask

    initial begin
        logic [31:0] r;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        check_all();
        ahb(1'b0, `OFS_CTRL, 32'h0, r);
        chk(r, `CTRL_RESET);
        ahb(1'b1, 8'h40, 32'hffffffff, r);
        ahb(1'b0, 8'h40, 32'h0, r);
        chk(r, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        // Every write mode on every channel, boundary data included
        for (int m = 0; m < 3; m++) begin
            for (int a = 0; a < 4; a++) begin
                word({2'(a), 2'(m), (a == 3) ? 12'hfff : 12'(a * 300 + m)}, 16, 0);
            end
        end
        // Each termination, then a hold-mode write wakes the outputs
        for (int t = 0; t < 4; t++) begin
            word({2'(t), 2'h3, 12'h555}, 16, 0);
        end
        word(16'h40a8, 16, 0);
        word(16'h3fff, 15, 0);
        word(16'h6abc, 20, 0);
        word(16'h2f0c, 16, 1);
        // Execution disabled: words counted only
        ahb(1'b1, `OFS_CTRL, 32'h0, r);
        ahb(1'b0, `OFS_CTRL, 32'h0, r);
        chk(r, 32'h0);
        exec = 1'b0;
        word(16'h2123, 16, 0);
        ahb(1'b1, `OFS_CTRL, 32'h1, r);
        exec = 1'b1;
        // Frozen enable: the sampler never sees this frame, so nothing moves
        @(posedge clk_sys);
        ce <= 1'b0;
        host.send(16'h2abc, 16, 0);
        @(posedge clk_sys);
        ce <= 1'b1;
        check_all();
        // Random words, some cut short, some sent as two bytes
        repeat (20) begin
            seed = xs(seed);
            word(seed[15:0], (seed[20:17] == 4'h0) ? 15 : 16, seed[21]);
        end
        end_of_test();
    end
endmodule
